// ---- rfb_pkg.sv ----
// constants for the registered fanout buffer
package rfb_pkg;
	localparam int RFB_DATA_W = 24;
	localparam int RFB_OUT_W = 48;
	localparam logic [RFB_DATA_W-1:0] RFB_OUT_RST = 24'h000000;
	// idle clock phase held while receivers are off: true high, complement low
	localparam logic RFB_TRUE_IDLE = 1'h1;
	localparam logic RFB_COMP_IDLE = 1'h0;

	typedef struct packed {
		logic prevTrue;
		logic prevComp;
		logic [RFB_DATA_W-1:0] copyA;
		logic [RFB_DATA_W-1:0] copyB;
	} rfb_state_t;
endpackage

// ---- rfb_registered_fanout_buffer.sv ----
// registered 24-in, 48-out fanout buffer with differential clock capture
module rfb_registered_fanout_buffer
	import rfb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic resetN,
	input wire logic clkTrue,
	input wire logic clkComp,
	input wire logic [RFB_DATA_W-1:0] dataIn,
	output logic [RFB_DATA_W-1:0] firstCopyOutput,
	output logic [RFB_DATA_W-1:0] secondCopyOutput
);
	rfb_state_t state_r;
	rfb_state_t state_nxt;
	logic crossing;
	logic [RFB_DATA_W-1:0] nextA;
	logic [RFB_DATA_W-1:0] nextB;

	// crossing seen only from a phase sampled while receivers were enabled
	assign crossing = resetN && clkTrue && !clkComp
		&& !state_r.prevTrue && state_r.prevComp;

	// one slice per input bit; both copies take the same captured level
	genvar bitIdx;
	for (bitIdx = 0; bitIdx < RFB_DATA_W; bitIdx++) begin : gen_bit
		assign nextA[bitIdx] = crossing ? dataIn[bitIdx] : state_r.copyA[bitIdx];
		assign nextB[bitIdx] = crossing ? dataIn[bitIdx] : state_r.copyB[bitIdx];

		chk_bit_pairing: assert property (
			@(posedge clk) disable iff (rst)
			firstCopyOutput[bitIdx] == secondCopyOutput[bitIdx])
			else $error("bit copies differ");

		chk_bit_capture: assert property (
			@(posedge clk) disable iff (rst)
			crossing
			|=> secondCopyOutput[bitIdx] == $past(dataIn[bitIdx]))
			else $error("bit not captured at clock crossing");
	end

	always_comb begin
		state_nxt = state_r;
		if (!resetN) begin
			// receivers off: park clock history so release cannot fake an edge
			state_nxt.prevTrue = RFB_TRUE_IDLE;
			state_nxt.prevComp = RFB_COMP_IDLE;
			state_nxt.copyA = RFB_OUT_RST;
			state_nxt.copyB = RFB_OUT_RST;
		end else begin
			state_nxt.prevTrue = clkTrue;
			state_nxt.prevComp = clkComp;
			state_nxt.copyA = nextA;
			state_nxt.copyB = nextB;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r.prevTrue <= RFB_TRUE_IDLE;
			state_r.prevComp <= RFB_COMP_IDLE;
			state_r.copyA <= RFB_OUT_RST;
			state_r.copyB <= RFB_OUT_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign firstCopyOutput = state_r.copyA;
	assign secondCopyOutput = state_r.copyB;

	chk_copies_match: assert property (@(posedge clk) disable iff (rst)
		firstCopyOutput == secondCopyOutput)
		else $error("output copies differ");

	chk_capture_on_cross: assert property (@(posedge clk) disable iff (rst)
		crossing |=> (firstCopyOutput == $past(dataIn)) && (secondCopyOutput == $past(dataIn)))
		else $error("data not captured at clock crossing");

	chk_reset_clears: assert property (@(posedge clk) disable iff (rst)
		!resetN |=> (firstCopyOutput == RFB_OUT_RST) && (secondCopyOutput == RFB_OUT_RST))
		else $error("outputs not low after reset low");

	chk_release_no_edge: assert property (@(posedge clk) disable iff (rst)
		!resetN ##1 resetN |=> (firstCopyOutput == RFB_OUT_RST))
		else $error("capture from clock seen while receivers off");

	chk_hold_no_cross: assert property (@(posedge clk) disable iff (rst)
		(resetN && !crossing) |=> $stable(firstCopyOutput) && $stable(secondCopyOutput))
		else $error("outputs changed without a clock crossing");

	// system reset: same effect as the documented reset
	chk_rst_clears: assert property (
		@(posedge clk)
		rst
		|=> (firstCopyOutput == RFB_OUT_RST) && (secondCopyOutput == RFB_OUT_RST))
		else $error("outputs not low after system reset");

	chk_rst_parks: assert property (
		@(posedge clk)
		rst
		|=> (state_r.prevTrue == RFB_TRUE_IDLE) && (state_r.prevComp == RFB_COMP_IDLE))
		else $error("clock history not parked by system reset");

	chk_rst_release_quiet: assert property (
		@(posedge clk)
		$fell(rst)
		|-> (firstCopyOutput == RFB_OUT_RST) && (secondCopyOutput == RFB_OUT_RST))
		else $error("outputs not low at system reset release");

	// standby: receivers off, nothing on the inputs may reach the registers
	chk_standby_parks: assert property (
		@(posedge clk) disable iff (rst)
		!resetN
		|=> (state_r.prevTrue == RFB_TRUE_IDLE) && (state_r.prevComp == RFB_COMP_IDLE))
		else $error("clock history not parked in standby");

	chk_standby_stays: assert property (
		@(posedge clk) disable iff (rst)
		!resetN ##1 !resetN
		|-> (firstCopyOutput == RFB_OUT_RST) && (secondCopyOutput == RFB_OUT_RST))
		else $error("outputs left low level during standby");

	chk_float_data_ignored: assert property (
		@(posedge clk) disable iff (rst)
		!resetN && $changed(dataIn)
		|=> firstCopyOutput == RFB_OUT_RST)
		else $error("data reached outputs in standby");

	chk_float_clock_ignored: assert property (
		@(posedge clk) disable iff (rst)
		!resetN && $changed(clkTrue)
		|=> secondCopyOutput == RFB_OUT_RST)
		else $error("clock reached outputs in standby");

	chk_release_second: assert property (
		@(posedge clk) disable iff (rst)
		!resetN ##1 resetN
		|=> secondCopyOutput == RFB_OUT_RST)
		else $error("second copy captured at standby release");

	// refused clock patterns leave the outputs alone
	chk_both_high_hold: assert property (
		@(posedge clk) disable iff (rst)
		resetN && clkTrue && clkComp
		|=> $stable(firstCopyOutput) && $stable(secondCopyOutput))
		else $error("outputs changed with both clock halves high");

	chk_both_low_hold: assert property (
		@(posedge clk) disable iff (rst)
		resetN && !clkTrue && !clkComp
		|=> $stable(firstCopyOutput) && $stable(secondCopyOutput))
		else $error("outputs changed with both clock halves low");

	chk_quiet_clock_hold: assert property (
		@(posedge clk) disable iff (rst)
		resetN && $stable(clkTrue) && $stable(clkComp)
		|=> $stable(firstCopyOutput) && $stable(secondCopyOutput))
		else $error("outputs changed with a still clock");

	chk_data_ignored: assert property (
		@(posedge clk) disable iff (rst)
		resetN && !crossing && $changed(dataIn)
		|=> $stable(firstCopyOutput) && $stable(secondCopyOutput))
		else $error("data change reached outputs without a crossing");

	chk_hold_after_capture: assert property (
		@(posedge clk) disable iff (rst)
		crossing ##1 (resetN && !crossing)
		|=> $stable(firstCopyOutput) && $stable(secondCopyOutput))
		else $error("captured value not held");

	chk_change_needs_cross: assert property (
		@(posedge clk) disable iff (rst)
		$changed(firstCopyOutput) && $past(resetN)
		|-> $past(crossing))
		else $error("outputs changed without a capture");

	chk_true_rise_only: assert property (
		@(posedge clk) disable iff (rst)
		resetN && clkTrue && !clkComp && $past(clkTrue)
		|=> $stable(firstCopyOutput) && $stable(secondCopyOutput))
		else $error("capture without a rise of the true clock");

	chk_comp_fall_only: assert property (
		@(posedge clk) disable iff (rst)
		resetN && clkTrue && !clkComp && !$past(clkComp)
		|=> $stable(firstCopyOutput) && $stable(secondCopyOutput))
		else $error("capture without a fall of the complement clock");

	chk_cross_spacing: assert property (
		@(posedge clk) disable iff (rst)
		crossing
		|=> !crossing)
		else $error("crossings closer than two cycles");

	chk_low_phase_first: assert property (
		@(posedge clk) disable iff (rst)
		crossing
		|-> !$past(clkTrue) && $past(clkComp) && $past(resetN))
		else $error("crossing without a preceding low phase");

	chk_capture_low_level: assert property (
		@(posedge clk) disable iff (rst)
		crossing && (dataIn == RFB_OUT_RST)
		|=> (firstCopyOutput == RFB_OUT_RST) && (secondCopyOutput == RFB_OUT_RST))
		else $error("low level not captured");

	chk_capture_high_level: assert property (
		@(posedge clk) disable iff (rst)
		crossing && (dataIn == ~RFB_OUT_RST)
		|=> (firstCopyOutput == ~RFB_OUT_RST) && (secondCopyOutput == ~RFB_OUT_RST))
		else $error("high level not captured");
endmodule

// ---- rfb_ctrl.sv ----
// controller model: differential clock, parked in its low phase when idle
module rfb_ctrl (
	input wire logic clk,
	input wire logic run,
	input wire logic stuck,
	input wire logic stuckLevel,
	output logic clkTrue,
	output logic clkComp
);
	timeunit 1ns;
	timeprecision 1ns;
	// stuck drives both halves to one level, a pattern the buffer must refuse
	always @(posedge clk) begin
		if (stuck) begin
			clkTrue <= stuckLevel;
			clkComp <= stuckLevel;
		end else if (run) begin
			clkTrue <= ~clkTrue;
			clkComp <= clkTrue;
		end else begin
			clkTrue <= 1'h0;
			clkComp <= 1'h1;
		end
	end
endmodule

// ---- rfb_registered_fanout_buffer_tb.sv ----
// bench for the fanout buffer
module rfb_registered_fanout_buffer_tb import rfb_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic resetN = 1'h0;
	logic run = 1'h0;
	logic stuck = 1'h0;
	logic stuckLevel = 1'h0;
	logic clkTrue;
	logic clkComp;
	logic [RFB_DATA_W-1:0] dataIn = 24'h000000;
	logic [RFB_DATA_W-1:0] firstCopyOutput;
	logic [RFB_DATA_W-1:0] secondCopyOutput;
	int err_count = 0;
	int comparisons = 0;
	rfb_registered_fanout_buffer u_rfb_registered_fanout_buffer (
		.clk(clk),
		.rst(rst),
		.resetN(resetN),
		.clkTrue(clkTrue),
		.clkComp(clkComp),
		.dataIn(dataIn),
		.firstCopyOutput(firstCopyOutput),
		.secondCopyOutput(secondCopyOutput)
	);
	rfb_ctrl u_rfb_ctrl (
		.clk(clk),
		.run(run),
		.stuck(stuck),
		.stuckLevel(stuckLevel),
		.clkTrue(clkTrue),
		.clkComp(clkComp)
	);
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic chk(logic [RFB_OUT_W-1:0] s, logic [RFB_OUT_W-1:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %0t output mismatch", $time);
		end
	endtask
	// one low-to-high crossing; the capture shows exactly one cycle later
	task automatic grab(logic [RFB_DATA_W-1:0] v, logic [RFB_DATA_W-1:0] prev);
		@(posedge clk);
		run <= 1'h1;
		dataIn <= v;
		@(posedge clk);
		run <= 1'h0;
		@(negedge clk);
		chk({firstCopyOutput, secondCopyOutput}, {prev, prev});
		@(negedge clk);
		chk({firstCopyOutput, secondCopyOutput}, {v, v});
		@(posedge clk);
		dataIn <= ~v;
		repeat (3) @(negedge clk);
		chk({firstCopyOutput, secondCopyOutput}, {v, v});
	endtask
	task automatic refuse(logic [RFB_DATA_W-1:0] v, logic [RFB_DATA_W-1:0] held);
		@(posedge clk);
		stuck <= 1'h1;
		stuckLevel <= 1'h1;
		dataIn <= v;
		repeat (2) @(posedge clk);
		stuckLevel <= 1'h0;
		@(negedge clk);
		chk({firstCopyOutput, secondCopyOutput}, {held, held});
		repeat (2) @(posedge clk);
		stuck <= 1'h0;
		repeat (3) @(negedge clk);
		chk({firstCopyOutput, secondCopyOutput}, {held, held});
	endtask
	// floating data and a running clock in standby, then a release after the clock is parked
	task automatic standby(logic [RFB_DATA_W-1:0] held);
		@(posedge clk);
		resetN <= 1'h0;
		dataIn <= 24'hXXXXXX;
		run <= 1'h1;
		@(negedge clk);
		chk({firstCopyOutput, secondCopyOutput}, {held, held});
		repeat (4) @(negedge clk);
		chk({firstCopyOutput, secondCopyOutput}, '0);
		@(posedge clk);
		run <= 1'h0;
		dataIn <= 24'h000000;
		@(posedge clk);
		resetN <= 1'h1;
		repeat (2) @(negedge clk);
		chk({firstCopyOutput, secondCopyOutput}, '0);
	endtask
	task automatic results();
		if (err_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#2000;
		err_count++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		resetN <= 1'h1;
		grab(24'hA5C3F0, 24'h000000);
		grab(24'h000000, 24'hA5C3F0);
		refuse(24'hFFFFFF, 24'h000000);
		grab(24'h5A3C0F, 24'h000000);
		standby(24'h5A3C0F);
		grab(24'hFFFFFF, 24'h000000);
		results();
	end
endmodule
